// >>> design/ubaw_pkg.sv
// constants and types for the baud generator, auto-baud and wake block
// assumes one system clock; all inputs synchronous to it
package ubaw_pkg;
    localparam int          DIV_W            = 16;
    localparam logic [15:0] DIV_RESET        = 16'h0000;
    localparam logic [15:0] AB_CNT_MAX       = 16'hffff;
    localparam logic [3:0]  HS_SUB_LAST      = 4'h3;   // 4 baud clocks per bit
    localparam logic [3:0]  NORM_SUB_LAST    = 4'hf;   // 16 baud clocks per bit
    localparam logic [6:0]  HS_AB_PRE_LAST   = 7'h1f;  // clock / 32
    localparam logic [6:0]  NORM_AB_PRE_LAST = 7'h7f;  // clock / 128
    localparam logic [2:0]  SYNC_EDGE_LAST   = 3'h4;   // four seen, next is fifth
    localparam logic [3:0]  MODE_ASYNC8      = 4'h0;
    localparam logic [3:0]  MODE_LIN_CLIENT  = 4'hb;
    localparam logic [3:0]  MODE_LIN_HOST    = 4'hc;
    localparam int          FIFO_DEPTH       = 32;
    localparam int          FIFO_W           = 17;     // overflow bit + 16-bit count
    typedef enum logic [1:0] {AB_OFF, AB_WAIT, AB_COUNT, AB_TAIL} ubaw_ab_state_t;
endpackage

// >>> design/ubaw_top.sv
// baud timer, auto-baud measurement, wake-on-break and activity hook,
// plus the result fifo; assumes synchronous receive/transmit line inputs
`timescale 1ns/100ps

module ubaw_fifo #(
    parameter int W     = ubaw_pkg::FIFO_W,
    parameter int DEPTH = ubaw_pkg::FIFO_DEPTH
) (
    input  wire logic         i_ref_clk,  // system clock
    input  wire logic         i_nrst,     // async reset, active low
    input  wire logic         i_valid,    // write request
    output logic              o_ready,    // room for a word
    input  wire logic [W-1:0] i_data,     // write word
    output logic              o_valid,    // head word present
    input  wire logic         i_ready,    // drain accepts head
    output logic [W-1:0]      o_data      // head word
);
    localparam int AW = $clog2(DEPTH);
    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
            $error("fifo depth must be a power of two, at least 2");
        end
    endgenerate

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [AW:0]   mcnt, next_mcnt;
    logic          head_valid, next_head_valid, next_ready;
    logic [W-1:0]  head_data, next_head_data;
    logic          push, pop, head_free, mem_push, mem_pop;

    // head sits in its own register so the drain side sees flop outputs
    always_comb begin
        push            = i_valid & o_ready;
        pop             = head_valid & i_ready;
        head_free       = ~head_valid | pop;
        mem_pop         = head_free & (mcnt != '0);
        mem_push        = push & ~(head_free & (mcnt == '0));
        next_head_valid = head_valid & ~pop;
        next_head_data  = head_data;
        if (mem_pop) begin
            next_head_valid = 1'b1;
            next_head_data  = mem[rd_ptr];
        end else if (head_free && push) begin
            next_head_valid = 1'b1;
            next_head_data  = i_data;
        end
        next_rd_ptr = mem_pop ? rd_ptr + 1'b1 : rd_ptr;
        next_wr_ptr = mem_push ? wr_ptr + 1'b1 : wr_ptr;
        next_mcnt   = mcnt + {{AW{1'b0}}, mem_push} - {{AW{1'b0}}, mem_pop};
        next_ready  = (32'(next_mcnt) + 32'(next_head_valid)) < DEPTH;
    end

    always_ff @(posedge i_ref_clk) begin
        if (mem_push) begin
            mem[wr_ptr] <= i_data;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wr_ptr     <= '0;
            rd_ptr     <= '0;
            mcnt       <= '0;
            head_valid <= 1'b0;
            head_data  <= '0;
            o_ready    <= 1'b1;
        end else begin
            wr_ptr     <= next_wr_ptr;
            rd_ptr     <= next_rd_ptr;
            mcnt       <= next_mcnt;
            head_valid <= next_head_valid;
            head_data  <= next_head_data;
            o_ready    <= next_ready;
        end
    end
    assign o_valid = head_valid;
    assign o_data  = head_data;
endmodule

// Summary of operation
// RULE1 - sixteen-bit free-running baud timer, period from software divisor
// RULE2 - baud is clock/(4(div+1)) high speed, clock/(16(div+1)) normal
// RULE3 - writing the divisor clears the baud timer at once
// RULE4 - software auto-baud only in 8-bit async; LIN arms it per packet
// RULE5 - receive line times the counter across the five falls of 55h
// RULE6 - first fall starts counting; receiver held idle until sequence ends
// RULE7 - fifth fall loads divisor, clears enable, sets sticky done flag
// RULE8 - receive idle drops at first fall, returns at fifth rise
// RULE9 - measurement counter ticks at clock/32 or clock/128
// RULE10 - count kept internally; visible divisor unchanged until success
// RULE11 - overflow sets flag, waits fifth fall, sets done, divisor kept
// RULE12 - overflow interrupt needs its enable, port error and global enables
// RULE13 - software aborts by clearing enable first, then overflow flag
// RULE14 - with wake and auto-baud both set, measure the char after break
// RULE15 - wake enable suppresses reception and watches line for activity
// RULE16 - wake flag set at wake event, in sleep from line level
// RULE17 - wake enable self-clears when line returns idle after break
// RULE18 - nonzero char: low time to first rise is the wake event
// RULE19 - sender opens with all-zero wake char of eleven-plus bit times
// RULE20 - software checks receive idle before setting wake enable
// RULE21 - software checks receiver idle before changing the clock
// RULE22 - any line activity pulses a restart to the limit timer
module ubaw_top (
    input  wire logic        i_ref_clk,          // system clock
    input  wire logic        i_nrst,             // async reset, active low
    input  wire logic        i_rx,               // receive line, idle high
    input  wire logic        i_tx,               // transmit line, idle high
    input  wire logic [3:0]  i_mode,             // port mode select
    input  wire logic        i_speed_select,     // 1: 4 baud clocks per bit
    input  wire logic        i_div_wr,           // divisor write strobe
    input  wire logic [15:0] i_div_wdata,        // divisor write value
    input  wire logic        i_autobaud_set,     // software sets enable
    input  wire logic        i_autobaud_clr,     // software clears enable
    input  wire logic        i_lin_packet_start, // LIN break seen, arm measure
    input  wire logic        i_done_clr,         // clear done flag
    input  wire logic        i_ovf_clr,          // clear overflow flag
    input  wire logic        i_ovf_int_enable,   // overflow interrupt enable
    input  wire logic        i_port_err_int_enable, // port error int enable
    input  wire logic        i_port_int_enable,  // port interrupt enable
    input  wire logic        i_global_int_enable,// global interrupt enable
    input  wire logic        i_wake_enable_set,  // software sets wake enable
    input  wire logic        i_wake_enable_clr,  // software clears wake enable
    input  wire logic        i_wake_flag_clr,    // clear wake flag
    input  wire logic        i_sleep,            // device in sleep
    input  wire logic        i_rx_busy,          // character receiver busy
    input  wire logic        i_meas_ready,       // result drain ready
    output logic [15:0]      o_baud_divisor,     // visible divisor
    output logic             o_baud_tick,        // one baud clock
    output logic             o_bit_tick,         // one bit period
    output logic             o_autobaud_enable,  // software auto-baud enable
    output logic             o_autobaud_done_flag,     // sticky done
    output logic             o_autobaud_overflow_flag, // sticky overflow
    output logic             o_ovf_irq,          // overflow interrupt
    output logic             o_wake_enable,      // wake armed
    output logic             o_wake_flag,        // sticky wake flag
    output logic             o_wake_irq,         // wake interrupt
    output logic             o_receive_idle,     // no reception in progress
    output logic             o_rx_hold_idle,     // receive machine held idle
    output logic             o_limit_timer_restart, // activity pulse
    output logic             o_meas_valid,       // result word valid
    output logic [16:0]      o_meas_data         // {overflow, count}
);
    logic        prev_rx, prev_tx, rx_fall, rx_rise, tx_edge;
    logic [15:0] baud_divisor, next_baud_divisor, brg_cnt, next_brg_cnt;
    logic [3:0]  sub_cnt, next_sub_cnt, sub_last;
    logic        next_baud_tick, next_bit_tick;
    ubaw_pkg::ubaw_ab_state_t ab_state, next_ab_state;
    logic [6:0]  ab_pre, next_ab_pre, pre_last;
    logic [15:0] ab_cnt, next_ab_cnt;
    logic [2:0]  fall_cnt, next_fall_cnt, rise_cnt, next_rise_cnt;
    logic        ab_ovf_seen, next_ab_ovf_seen;
    logic        autobaud_enable, next_autobaud_enable, done_flag, next_done_flag;
    logic        ovf_flag, next_ovf_flag, ab_load, ab_finish, ab_arm, async8, lin_mode;
    logic        wake_enable, next_wake_enable, wake_flag, next_wake_flag;
    logic        wake_seen, next_wake_seen, wake_event;
    logic        next_receive_idle, next_rx_hold_idle;
    logic        fifo_ready;

    assign rx_fall  = prev_rx & ~i_rx;
    assign rx_rise  = ~prev_rx & i_rx;
    assign tx_edge  = prev_tx ^ i_tx;
    assign async8   = (i_mode == ubaw_pkg::MODE_ASYNC8);
    assign lin_mode = (i_mode == ubaw_pkg::MODE_LIN_CLIENT) ||
                      (i_mode == ubaw_pkg::MODE_LIN_HOST);
    assign sub_last = i_speed_select ? ubaw_pkg::HS_SUB_LAST : ubaw_pkg::NORM_SUB_LAST;
    assign pre_last = i_speed_select ? ubaw_pkg::HS_AB_PRE_LAST
                                     : ubaw_pkg::NORM_AB_PRE_LAST; // RULE9

    // baud timer
    always_comb begin
        next_baud_divisor = baud_divisor;
        next_brg_cnt      = brg_cnt + 16'h0001;
        next_sub_cnt      = sub_cnt;
        next_baud_tick    = 1'b0;
        next_bit_tick     = 1'b0;
        if (i_div_wr || ab_load) begin
            next_baud_divisor = i_div_wr ? i_div_wdata
                              : ((ab_cnt == 16'h0000) ? 16'h0000 : ab_cnt - 16'h0001);
            next_brg_cnt      = 16'h0000; // RULE3
            next_sub_cnt      = 4'h0;
        end else if (brg_cnt >= baud_divisor) begin // RULE1
            next_brg_cnt   = 16'h0000;
            next_baud_tick = 1'b1;
            if (sub_cnt >= sub_last) begin // RULE2
                next_sub_cnt  = 4'h0;
                next_bit_tick = 1'b1;
            end else begin
                next_sub_cnt = sub_cnt + 4'h1;
            end
        end
    end

    // auto-baud measurement; arming needs fifo room so no result is lost
    always_comb begin
        ab_arm = fifo_ready && ((autobaud_enable && async8) ||
                                (lin_mode && i_lin_packet_start)); // RULE4
        next_ab_state    = ab_state;
        next_ab_pre      = ab_pre;
        next_ab_cnt      = ab_cnt;
        next_fall_cnt    = fall_cnt;
        next_rise_cnt    = rise_cnt;
        next_ab_ovf_seen = ab_ovf_seen;
        ab_load          = 1'b0;
        ab_finish        = 1'b0;
        next_ovf_flag    = ovf_flag & ~i_ovf_clr;
        case (ab_state)
            ubaw_pkg::AB_OFF: begin
                if (ab_arm) begin
                    next_ab_state = ubaw_pkg::AB_WAIT;
                end
            end
            ubaw_pkg::AB_WAIT: begin
                if (async8 && !autobaud_enable && !lin_mode) begin
                    next_ab_state = ubaw_pkg::AB_OFF; // RULE13
                end else if (rx_fall && !wake_enable) begin // RULE14
                    next_ab_state    = ubaw_pkg::AB_COUNT; // RULE6
                    next_ab_pre      = 7'h00;
                    next_ab_cnt      = 16'h0000;
                    next_fall_cnt    = 3'h1;
                    next_rise_cnt    = 3'h0;
                    next_ab_ovf_seen = 1'b0;
                end
            end
            ubaw_pkg::AB_COUNT: begin
                next_ab_pre = (ab_pre >= pre_last) ? 7'h00 : ab_pre + 7'h01;
                if (ab_pre >= pre_last) begin
                    if (ab_cnt == ubaw_pkg::AB_CNT_MAX) begin
                        next_ovf_flag    = 1'b1; // RULE11
                        next_ab_ovf_seen = 1'b1;
                    end else begin
                        next_ab_cnt = ab_cnt + 16'h0001; // RULE10
                    end
                end
                if (rx_rise) begin
                    next_rise_cnt = rise_cnt + 3'h1;
                end
                if (async8 && !autobaud_enable && !lin_mode) begin
                    next_ab_state = ubaw_pkg::AB_OFF;
                end else if (rx_fall) begin // RULE5
                    next_fall_cnt = fall_cnt + 3'h1;
                    if (fall_cnt == ubaw_pkg::SYNC_EDGE_LAST) begin
                        ab_finish     = 1'b1; // RULE7
                        ab_load       = ~ab_ovf_seen; // RULE11
                        next_ab_state = ubaw_pkg::AB_TAIL;
                    end
                end
            end
            ubaw_pkg::AB_TAIL: begin
                if (rx_rise) begin
                    next_rise_cnt = rise_cnt + 3'h1;
                    if (rise_cnt == ubaw_pkg::SYNC_EDGE_LAST) begin
                        next_ab_state = ubaw_pkg::AB_OFF; // RULE8
                    end
                end
            end
            default: next_ab_state = ubaw_pkg::AB_OFF;
        endcase
        // software set beats the hardware clear; set of a flag beats its clear
        next_autobaud_enable = (i_autobaud_set && async8) ||
                               (autobaud_enable && !ab_finish && !i_autobaud_clr);
        next_done_flag       = ab_finish | (done_flag & ~i_done_clr); // RULE7
        next_receive_idle    = !i_rx_busy && (next_ab_state != ubaw_pkg::AB_COUNT) &&
                               (next_ab_state != ubaw_pkg::AB_TAIL); // RULE8
    end

    // wake-on-break
    always_comb begin
        wake_event       = wake_enable && !wake_seen &&
                           (i_sleep ? !i_rx : rx_fall); // RULE16
        next_wake_flag   = wake_event | (wake_flag & ~i_wake_flag_clr); // RULE16
        next_wake_seen   = (wake_seen | wake_event) & ~i_wake_enable_clr;
        next_wake_enable = i_wake_enable_set |
                           (wake_enable & ~i_wake_enable_clr);
        if (wake_seen && rx_rise) begin // RULE17 RULE18
            next_wake_enable = i_wake_enable_set;
            next_wake_seen   = 1'b0;
        end
        next_rx_hold_idle = next_wake_enable ||
                            (next_ab_state != ubaw_pkg::AB_OFF); // RULE15 RULE6
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            prev_rx               <= 1'b1;
            prev_tx               <= 1'b1;
            baud_divisor          <= ubaw_pkg::DIV_RESET;
            brg_cnt               <= 16'h0000;
            sub_cnt               <= 4'h0;
            o_baud_tick           <= 1'b0;
            o_bit_tick            <= 1'b0;
            ab_state              <= ubaw_pkg::AB_OFF;
            ab_pre                <= 7'h00;
            ab_cnt                <= 16'h0000;
            fall_cnt              <= 3'h0;
            rise_cnt              <= 3'h0;
            ab_ovf_seen           <= 1'b0;
            autobaud_enable       <= 1'b0;
            done_flag             <= 1'b0;
            ovf_flag              <= 1'b0;
            wake_enable           <= 1'b0;
            wake_flag             <= 1'b0;
            wake_seen             <= 1'b0;
            o_receive_idle        <= 1'b1;
            o_rx_hold_idle        <= 1'b0;
            o_ovf_irq             <= 1'b0;
            o_wake_irq            <= 1'b0;
            o_limit_timer_restart <= 1'b0;
        end else begin
            prev_rx               <= i_rx;
            prev_tx               <= i_tx;
            baud_divisor          <= next_baud_divisor;
            brg_cnt               <= next_brg_cnt;
            sub_cnt               <= next_sub_cnt;
            o_baud_tick           <= next_baud_tick;
            o_bit_tick            <= next_bit_tick;
            ab_state              <= next_ab_state;
            ab_pre                <= next_ab_pre;
            ab_cnt                <= next_ab_cnt;
            fall_cnt              <= next_fall_cnt;
            rise_cnt              <= next_rise_cnt;
            ab_ovf_seen           <= next_ab_ovf_seen;
            autobaud_enable       <= next_autobaud_enable;
            done_flag             <= next_done_flag;
            ovf_flag              <= next_ovf_flag;
            wake_enable           <= next_wake_enable;
            wake_flag             <= next_wake_flag;
            wake_seen             <= next_wake_seen;
            o_receive_idle        <= next_receive_idle;
            o_rx_hold_idle        <= next_rx_hold_idle;
            o_ovf_irq             <= ovf_flag & i_ovf_int_enable &
                                     i_port_err_int_enable & i_global_int_enable; // RULE12
            o_wake_irq            <= wake_flag & i_port_int_enable & i_global_int_enable;
            o_limit_timer_restart <= rx_fall | rx_rise | tx_edge; // RULE22
        end
    end

    assign o_baud_divisor           = baud_divisor;
    assign o_autobaud_enable        = autobaud_enable;
    assign o_autobaud_done_flag     = done_flag;
    assign o_autobaud_overflow_flag = ovf_flag;
    assign o_wake_enable            = wake_enable;
    assign o_wake_flag              = wake_flag;

    ubaw_fifo #(.W(ubaw_pkg::FIFO_W), .DEPTH(ubaw_pkg::FIFO_DEPTH)) u_fifo (
        .i_ref_clk (i_ref_clk),
        .i_nrst    (i_nrst),
        .i_valid   (ab_finish),
        .o_ready   (fifo_ready),
        .i_data    ({ab_ovf_seen, ab_cnt}),
        .o_valid   (o_meas_valid),
        .i_ready   (i_meas_ready),
        .o_data    (o_meas_data)
    );

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);

    AST_DIV_WR_CLEARS: assert property (i_div_wr |=> brg_cnt == 16'h0000 && // RULE3
        baud_divisor == $past(i_div_wdata)) else $error("divisor write did not restart timer");
    AST_SUB_RANGE: assert property (i_speed_select && $past(i_speed_select) && // RULE2
        !$past(i_div_wr) |-> sub_cnt <= ubaw_pkg::HS_SUB_LAST) else $error("bad sub count");
    AST_AB_LOAD: assert property (ab_load && !i_div_wr |=> // RULE7
        baud_divisor == $past(ab_cnt) - 16'h0001 || $past(ab_cnt) == 16'h0000)
        else $error("measured divisor not loaded");
    AST_AB_KEEP: assert property (ab_state == ubaw_pkg::AB_COUNT && !ab_load && // RULE10
        !i_div_wr |=> $stable(baud_divisor)) else $error("divisor moved mid-measure");
    AST_OVF_NOLOAD: assert property (ab_finish && ab_ovf_seen && !i_div_wr && // RULE11
        !i_autobaud_set |=> $stable(baud_divisor) && done_flag && !autobaud_enable)
        else $error("overflow handling wrong");
    AST_IDLE_LOW: assert property (ab_state == ubaw_pkg::AB_COUNT |-> // RULE8
        !o_receive_idle) else $error("receive idle high during measure");
    AST_OVF_IRQ: assert property (o_ovf_irq |-> $past(ovf_flag) && // RULE12
        $past(i_port_err_int_enable) && $past(i_global_int_enable) &&
        $past(i_ovf_int_enable)) else $error("overflow irq without enables");
    AST_WAKE_SET: assert property (wake_enable && !wake_seen && !i_sleep && rx_fall // RULE16
        |=> wake_flag [*2]) else $error("wake flag not set and held");
    AST_WAKE_HOLD: assert property (wake_enable |-> o_rx_hold_idle) // RULE15
        else $error("receiver not held idle while wake armed");
    AST_WAIT_WAKE: assert property (ab_state == ubaw_pkg::AB_WAIT && wake_enable // RULE14
        |=> ab_state != ubaw_pkg::AB_COUNT) else $error("measured the break");
    AST_ACTIVITY: assert property ((rx_fall || rx_rise || tx_edge) |=> // RULE22
        o_limit_timer_restart) else $error("activity did not restart timer");

    COV_AB_DONE: cover property (ab_load ##1 done_flag);
    COV_AB_OVF: cover property (ab_finish && ab_ovf_seen);
    COV_WAKE: cover property (wake_event ##[1:1000] !wake_enable);
    COV_FIFO_FULL: cover property (!fifo_ready);
endmodule

// >>> verification/ubaw_line_tx.sv
// remote serial sender model driving the receive line of the block
// assumes the bench clock; the line idles high between frames
`timescale 1ns/100ps
module ubaw_line_tx (
    input  wire logic i_ref_clk, // system clock
    output logic      o_rx       // receive line, idle high
);
    initial o_rx = 1'b1;
    // start bit, nbits lsb first, stop bit; call just after a rising edge
    task automatic send(input logic [15:0] b, input int bit_clk, input int nbits);
        for (int i = 0; i < nbits + 2; i++) begin
            o_rx <= (i == 0) ? 1'b0 : (i > nbits) ? 1'b1 : b[i-1];
            repeat (bit_clk) @(posedge i_ref_clk);
        end
    endtask
endmodule

// >>> verification/ubaw_top_test.sv
// self-checking bench for the baud generator, auto-baud and wake block
// assumes ubaw_top and the sender model ubaw_line_tx are compiled first
`timescale 1ns/100ps
module ubaw_top_test;
    logic i_ref_clk, i_nrst, i_rx, i_tx, i_speed_select, i_div_wr, i_autobaud_set;
    logic i_autobaud_clr, i_lin_packet_start, i_done_clr, i_ovf_clr, i_ovf_int_enable;
    logic i_port_err_int_enable, i_port_int_enable, i_global_int_enable, i_wake_enable_set;
    logic i_wake_enable_clr, i_wake_flag_clr, i_sleep, i_rx_busy, i_meas_ready;
    logic [3:0]  i_mode;
    logic [15:0] i_div_wdata, o_baud_divisor;
    logic [16:0] o_meas_data;
    logic o_baud_tick, o_bit_tick, o_autobaud_enable, o_autobaud_done_flag, o_wake_irq;
    logic o_autobaud_overflow_flag, o_ovf_irq, o_wake_enable, o_wake_flag, o_meas_valid;
    logic o_receive_idle, o_rx_hold_idle, o_limit_timer_restart;
    int bad_count = 0, compares = 0, seed = 55, n, d;
    int exp_q[$];
    ubaw_top dut_u (.*);
    ubaw_line_tx line_u (.i_ref_clk(i_ref_clk), .o_rx(i_rx));
    always #2 i_ref_clk = ~i_ref_clk;
    task automatic complete_run();
        if (bad_count == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic bound(input int cnt, input int lim);
        if (cnt >= lim) begin
            check(cnt, 0);
            complete_run();
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge i_ref_clk);
    endtask
    // 0x55 at 128 clocks a bit, high speed: 1024 clocks / 32 = 32 ticks
    task automatic measure();
        fork
            line_u.send(16'h0055, 128, 8);
            begin
                repeat (40) @(negedge i_ref_clk);
                check(o_receive_idle, 0);
                check(o_rx_hold_idle, 1);
                check(o_baud_divisor, d);
            end
        join
        @(negedge i_ref_clk);
        check(o_autobaud_done_flag, 1);
        check(o_autobaud_enable, 0);
        check(o_receive_idle, 1);
        check(o_baud_divisor >= 30 && o_baud_divisor <= 32, 1);
        check({o_meas_valid, o_meas_data[16]}, 2'b10);
        check({o_autobaud_overflow_flag, o_ovf_irq}, 2'b00);
        d = o_baud_divisor;
        exp_q.push_back(32);
        @(posedge i_ref_clk);
        i_done_clr <= 1'b1;
        cyc(1);
        i_done_clr <= 1'b0;
    endtask
    initial begin
        {i_ref_clk, i_nrst, i_speed_select, i_div_wr, i_autobaud_set, i_autobaud_clr} = '0;
        {i_lin_packet_start, i_done_clr, i_ovf_clr, i_sleep} = '0;
        {i_wake_enable_set, i_wake_enable_clr, i_wake_flag_clr} = '0;
        {i_rx_busy, i_meas_ready, i_mode, i_div_wdata} = '0;
        {i_tx, i_port_int_enable, i_global_int_enable} = 3'b111;
        {i_ovf_int_enable, i_port_err_int_enable} = 2'b11;
        cyc(5);
        i_nrst <= 1'b1;
        for (int sp = 0; sp < 2; sp++) begin
            check(o_receive_idle, 1);
            d = 2 + $unsigned($random(seed)) % 6;
            @(posedge i_ref_clk);
            {i_speed_select, i_div_wr, i_div_wdata} <= {sp[0], 1'b1, d[15:0]};
            cyc(1);
            i_div_wr <= 1'b0;
            for (n = 0; n < 100 && !(n > 0 && o_baud_tick); n++) @(negedge i_ref_clk);
            bound(n, 100);
            check(n, d + 2);
            check(o_baud_divisor, d);
            for (n = 0; n < 9000 && !o_bit_tick; n++) @(negedge i_ref_clk);
            bound(n, 9000);
            @(negedge i_ref_clk);
            for (n = 1; n < 9000 && !o_bit_tick; n++) @(negedge i_ref_clk);
            bound(n, 9000);
            check(n, (d + 1) * (sp ? 4 : 16));
        end
        @(posedge i_ref_clk);
        i_autobaud_set <= 1'b1;
        cyc(1);
        i_autobaud_set <= 1'b0;
        cyc(2);
        check(o_autobaud_enable, 1);
        measure();
        i_mode <= 4'hb;
        i_autobaud_set <= 1'b1;
        cyc(1);
        {i_autobaud_set, i_lin_packet_start} <= 2'b01;
        cyc(1);
        i_lin_packet_start <= 1'b0;
        cyc(2);
        check({o_autobaud_enable, o_rx_hold_idle}, 2'b01);
        measure();
        check(o_receive_idle, 1);
        {i_mode, i_autobaud_set, i_wake_enable_set} <= 6'h03;
        cyc(1);
        {i_autobaud_set, i_wake_enable_set} <= 2'b00;
        cyc(2);
        check({o_wake_enable, o_rx_hold_idle}, 2'b11);
        fork
            line_u.send(16'h0000, 16, 11);
            begin
                repeat (20) @(negedge i_ref_clk);
                check({o_wake_flag, o_wake_enable, o_autobaud_done_flag}, 3'b110);
                check(o_receive_idle, 1);
            end
        join
        cyc(2);
        check({o_wake_enable, o_wake_flag, o_wake_irq}, 3'b011);
        measure();
        i_wake_flag_clr <= 1'b1;
        cyc(1);
        {i_wake_flag_clr, i_tx} <= 2'b00;
        for (n = 0, d = 0; n < 6; n++) begin
            @(negedge i_ref_clk);
            d += o_limit_timer_restart;
        end
        check(d, 1);
        check({o_wake_flag, o_wake_irq}, 2'b00);
        @(posedge i_ref_clk);
        {i_sleep, i_wake_enable_set} <= 2'b11;
        cyc(1);
        i_wake_enable_set <= 1'b0;
        line_u.send(16'h00f0, 4, 8);
        cyc(2);
        check({o_wake_flag, o_wake_enable}, 2'b10);
        {i_autobaud_set, i_sleep} <= 2'b10;
        cyc(1);
        i_autobaud_set <= 1'b0;
        cyc(2);
        line_u.send(16'h0000, 16, 1);
        check({o_receive_idle, o_rx_hold_idle}, 2'b01);
        i_autobaud_clr <= 1'b1;
        cyc(1);
        {i_autobaud_clr, i_ovf_clr} <= 2'b01;
        cyc(1);
        i_ovf_clr <= 1'b0;
        cyc(2);
        check({o_autobaud_enable, o_autobaud_done_flag}, 2'b00);
        check({o_rx_hold_idle, o_receive_idle}, 2'b01);
        i_meas_ready <= 1'b1;
        for (n = 0; n < 50 && (n == 0 || o_meas_valid); n++) begin
            @(negedge i_ref_clk);
            if (o_meas_valid) begin
                d = exp_q.pop_front() - int'(o_meas_data);
                check(d >= -1 && d <= 1, 1);
            end
        end
        bound(n, 50);
        check(exp_q.size(), 0);
        complete_run();
    end
endmodule
